// ===== sleep_wakeup_control.sv
// Purpose: deep sleep wake logic with its register file on AHB-Lite
// Assumes: one 20 MHz always-on clock, synchronous active-high reset
// Notes:   reads take one wait state, writes none
//
// Function
// - temperature change wakes unless measurement disabled
// - dc sense change wakes, sets flag bit 3
// - dc sense wake masked by enable bit 3
// - supply restore wakes always, sets flags
// - rtc interval wakes when enabled, sets flag
// - rtc alarm wakes when alarm fields enabled
// - irq zero pin wakes, edge select, pending kept
// - irq one pin wakes on 11x, pending kept
// - receive line edge wakes when function 11
// - reset pin low in sleep wakes battery run
// - display enable survives sleep
// - four scratch registers keep contents in sleep
// - pins inputs in sleep, pull-ups per pin
// - operating state follows switched supply source
// - wake from sleep restarts core from reset
//
// Design decision made here: register access over AHB-Lite.
`include "sleep_wakeup_control_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module sleep_wakeup_control (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        temp_change_evt,
  input  wire logic        dc_sense_change_evt,
  input  wire logic        rtc_interval_evt,
  input  wire logic        rtc_alarm_evt,
  input  wire logic        ext_irq_zero_n,
  input  wire logic        ext_irq_one_n,
  input  wire logic        second_uart_receive,
  input  wire logic        reset_pin_n,
  input  wire logic        switched_supply_source,
  output logic             wake_req,
  output logic             core_power_en,
  output logic             core_reset,
  output logic      [1:0]  op_state,
  output logic             lcd_enable,
  output logic             pins_input_only,
  output logic      [7:0]  port0_pullup,
  output logic      [7:0]  port1_pullup,
  output logic      [7:0]  port2_pullup,
  output logic             power_irq_req,
  output logic             rtc_irq_req
);
  import sleep_wakeup_control_pkg::*;

  // ========================================================================
  // register read decode
  function automatic logic [7:0] reg_read(input sw_state_t r,
                                          input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IDX_TIMER_CTRL:    v = r.timer_control;
      `IDX_RTC_CFG:       v = r.rtc_config;
      `IDX_RTC_CFG2:      v = r.rtc_config_second;
      `IDX_PULLUP0:       v = r.port0_pullup_enable;
      `IDX_PULLUP1:       v = r.port1_pullup_enable;
      `IDX_PULLUP2:       v = r.port2_pullup_enable;
      `IDX_POWER_CTRL:    v = r.power_control;
      `IDX_PWR_IRQ_EN:    v = r.power_irq_enables;
      `IDX_DELTA_CFG:     v = r.delta_threshold_config;
      `IDX_PERIPHERAL_CONFIG_CFG:    v = r.peripheral_config;
      `IDX_PWR_IRQ_FLAGS: v = r.power_irq_flags;
      `IDX_IRQ_PIN_CFG:   v = r.irq_pin_config;
      default:
      begin
        if (idx >= `IDX_SCRATCH1 && idx <= `IDX_SCRATCH4)
          v = r.retained_scratch[2'(idx - `IDX_SCRATCH1)];
        else
          v = 8'h00;
      end
    endcase
    return v;
  endfunction : reg_read

  sw_state_t s_q;
  sw_state_t s_d;

  logic [`NUM_PINS-1:0] pins;
  logic [`NUM_PINS-1:0] filt_new;
  logic [`NUM_PINS-1:0] edges;
  logic                 bus_sel;
  logic                 irq0_act;
  logic                 irq1_act;
  logic                 rx_edge;
  logic                 supply_up;
  logic                 mains;
  logic                 any_wake;
  logic [7:0]           wd;

  // ========================================================================
  // pin gathering
  assign pins = {switched_supply_source, reset_pin_n, second_uart_receive,
                 ext_irq_one_n, ext_irq_zero_n};

  // ========================================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    wd  = hwdata[7:0];
    // a change counts once stages two and three agree
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    filt_new  = (s_q.sync2 & ~(s_q.sync2 ^ s_q.sync3)) |
                (s_q.filt & (s_q.sync2 ^ s_q.sync3));
    s_d.filt  = filt_new;
    edges     = filt_new ^ s_q.filt;
    mains     = filt_new[`PIN_MAINS];
    supply_up = edges[`PIN_MAINS] & mains;

    // pin events: edge mode is a falling edge, else a low level
    irq0_act = s_q.timer_control[`TC_IRQ0_EDGE] ?
               (edges[`PIN_IRQ0] & ~filt_new[`PIN_IRQ0]) :
               ~filt_new[`PIN_IRQ0];
    irq1_act = s_q.timer_control[`TC_IRQ1_EDGE] ?
               (edges[`PIN_IRQ1] & ~filt_new[`PIN_IRQ1]) :
               ~filt_new[`PIN_IRQ1];
    rx_edge  = edges[`PIN_RX] &
               (s_q.peripheral_config[`PER_RX_FUNC_MSB:`PER_RX_FUNC_LSB]
                == `RX_WAKE_CODE);

    // qualified wake sources, all merged into one request
    any_wake =
      (temp_change_evt &
       s_q.delta_threshold_config[`DELTA_TEMP_EN]) |
      (dc_sense_change_evt &
       s_q.power_irq_enables[`PIE_DC_SENSE]) |
      (rtc_interval_evt & s_q.rtc_config[`RTC_INTERVAL_EN]) |
      (rtc_alarm_evt &
       (|s_q.rtc_config_second[`RTC2_ALARM_EN_MSB:
                               `RTC2_ALARM_EN_LSB])) |
      (irq0_act & s_q.irq_pin_config[`IPC_IRQ0_WAKE]) |
      (irq1_act &
       (s_q.irq_pin_config[`IPC_IRQ1_MSB:`IPC_IRQ1_LSB]
        == `IRQ1_WAKE_CODE)) |
      rx_edge |
      ~filt_new[`PIN_RESET];

    // bus: address phase captured, read gets one wait state
    bus_sel     = hsel & htrans[1] & hready;
    s_d.wr_pend = 1'b0;
    if (s_q.rd_wait)
    begin
      s_d.rdata   = {24'h000000, reg_read(s_q, s_q.idx)};
      s_d.ready   = 1'b1;
      s_d.rd_wait = 1'b0;
    end
    if (s_q.wr_pend)
    begin
      case (s_q.idx)
        `IDX_TIMER_CTRL:    s_d.timer_control = wd;
        `IDX_RTC_CFG:
        begin
          // flags clear on a written one, other bits plain
          s_d.rtc_config = wd;
          s_d.rtc_config[`RTC_INTERVAL_FLAG] =
            s_q.rtc_config[`RTC_INTERVAL_FLAG] & ~wd[`RTC_INTERVAL_FLAG];
          s_d.rtc_config[`RTC_ALARM_FLAG] =
            s_q.rtc_config[`RTC_ALARM_FLAG] & ~wd[`RTC_ALARM_FLAG];
        end
        `IDX_RTC_CFG2:      s_d.rtc_config_second = wd;
        `IDX_PULLUP0:       s_d.port0_pullup_enable = wd;
        `IDX_PULLUP1:       s_d.port1_pullup_enable = wd;
        `IDX_PULLUP2:       s_d.port2_pullup_enable = wd;
        `IDX_POWER_CTRL:    s_d.power_control = wd;
        `IDX_PWR_IRQ_EN:    s_d.power_irq_enables = wd;
        `IDX_DELTA_CFG:     s_d.delta_threshold_config = wd;
        `IDX_PERIPHERAL_CONFIG_CFG:
        begin
          s_d.peripheral_config = wd;
          s_d.peripheral_config[`PER_RX_EDGE_FLAG] =
            s_q.peripheral_config[`PER_RX_EDGE_FLAG] &
            ~wd[`PER_RX_EDGE_FLAG];
        end
        `IDX_PWR_IRQ_FLAGS: s_d.power_irq_flags = s_q.power_irq_flags & ~wd;
        `IDX_IRQ_PIN_CFG:   s_d.irq_pin_config = wd;
        default:
        begin
          // scratch writes only; unmapped writes are dropped
          if (s_q.idx >= `IDX_SCRATCH1 && s_q.idx <= `IDX_SCRATCH4)
            s_d.retained_scratch[2'(s_q.idx - `IDX_SCRATCH1)] = wd;
        end
      endcase
    end
    if (bus_sel)
    begin
      s_d.idx     = haddr[9:2];
      s_d.wr_pend = hwrite;
      if (!hwrite)
      begin
        s_d.ready   = 1'b0;
        s_d.rd_wait = 1'b1;
      end
    end

    // hardware sets after software clears, so a set wins
    if (dc_sense_change_evt)
      s_d.power_irq_flags[`PIF_DC_SENSE] = 1'b1;
    if (supply_up)
      s_d.power_irq_flags[`PIF_SUPPLY_REST] = 1'b1;
    if (rtc_interval_evt)
      s_d.rtc_config[`RTC_INTERVAL_FLAG] = 1'b1;
    if (rtc_alarm_evt)
      s_d.rtc_config[`RTC_ALARM_FLAG] = 1'b1;
    if (rx_edge)
      s_d.peripheral_config[`PER_RX_EDGE_FLAG] = 1'b1;
    s_d.peripheral_config[`PER_SUPPLY_SRC] = mains;
    // pending flags untouched while asleep
    if (s_q.state != DEEP_SLEEP && irq0_act)
      s_d.timer_control[`TC_IRQ0_PEND] = 1'b1;
    if (s_q.state != DEEP_SLEEP && irq1_act)
      s_d.timer_control[`TC_IRQ1_PEND] = 1'b1;

    // operating state machine
    s_d.wake_req = 1'b0;
    case (s_q.state)
      MAINS_RUN:
      begin
        if (!mains)
          s_d.state = BATTERY_RUN;
      end
      BATTERY_RUN:
      begin
        if (mains)
          s_d.state = MAINS_RUN;
        else if (s_q.power_control[`PC_SLEEP_REQ])
        begin
          s_d.state = DEEP_SLEEP;
          s_d.power_control[`PC_SLEEP_REQ] = 1'b0;
        end
      end
      DEEP_SLEEP:
      begin
        if (mains || any_wake)
        begin
          s_d.state    = WAKING;
          s_d.wake_req = 1'b1;
        end
      end
      WAKING:
      begin
        // core held in reset one cycle, then starts from its vector
        s_d.state = mains ? MAINS_RUN : BATTERY_RUN;
      end
      default:
        s_d.state = BATTERY_RUN;
    endcase

    // registered outputs
    s_d.core_power_en = (s_d.state != DEEP_SLEEP);
    s_d.core_reset    = (s_d.state == DEEP_SLEEP) ||
                        (s_d.state == WAKING);
    case (s_d.state)
      MAINS_RUN:   s_d.op_code = `OPSTATE_MAINS;
      DEEP_SLEEP:  s_d.op_code = `OPSTATE_SLEEP;
      default:     s_d.op_code = `OPSTATE_BATTERY;
    endcase
    s_d.power_irq_req = s_d.power_irq_flags[`PIF_SUPPLY_REST] |
                        (s_d.power_irq_flags[`PIF_DC_SENSE] &
                         s_d.power_irq_enables[`PIE_DC_SENSE]);
    s_d.rtc_irq_req   = s_d.rtc_config[`RTC_INTERVAL_FLAG] |
                        s_d.rtc_config[`RTC_ALARM_FLAG];

    // reset: every register to `REG_RST, bus ready
    if (srst)
    begin
      s_d               = '0;
      s_d.power_control = `REG_RST;
      s_d.ready         = 1'b1;
      s_d.core_power_en = 1'b1;
      // pins start at their pull-up level so no false edge follows reset
      s_d.sync1         = '1;
      s_d.sync2         = '1;
      s_d.sync3         = '1;
      s_d.filt          = '1;
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge core_clk)
  begin
    s_q <= s_d;
  end

  // ========================================================================
  // outputs from the state register, hresp tied to okay
  assign hrdata          = s_q.rdata;
  assign hreadyout       = s_q.ready;
  assign hresp           = 1'b0;
  assign wake_req        = s_q.wake_req;
  assign core_power_en   = s_q.core_power_en;
  assign core_reset      = s_q.core_reset;
  assign op_state        = s_q.op_code;
  assign lcd_enable      = s_q.power_control[`PC_LCD_EN];
  assign pins_input_only = (s_q.op_code == `OPSTATE_SLEEP);
  assign port0_pullup    = s_q.port0_pullup_enable;
  assign port1_pullup    = s_q.port1_pullup_enable;
  assign port2_pullup    = s_q.port2_pullup_enable;
  assign power_irq_req   = s_q.power_irq_req;
  assign rtc_irq_req     = s_q.rtc_irq_req;

endmodule : sleep_wakeup_control

`default_nettype wire

// ===== sleep_wakeup_control_defs.svh
// Purpose: register indices, field positions and codes for the wake logic
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef SLEEP_WAKEUP_CONTROL_DEFS_SVH
`define SLEEP_WAKEUP_CONTROL_DEFS_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define IDX_TIMER_CTRL     8'h88
`define IDX_RTC_CFG        8'hA1
`define IDX_RTC_CFG2       8'hA2
`define IDX_PULLUP0        8'hB2
`define IDX_PULLUP1        8'hB3
`define IDX_PULLUP2        8'hB4
`define IDX_POWER_CTRL     8'hC5
`define IDX_PWR_IRQ_EN     8'hEC
`define IDX_DELTA_CFG      8'hF3
`define IDX_PERIPHERAL_CONFIG_CFG     8'hF4
`define IDX_PWR_IRQ_FLAGS  8'hF8
`define IDX_SCRATCH1       8'hFB
`define IDX_SCRATCH4       8'hFE
`define IDX_IRQ_PIN_CFG    8'hFF

// ==========================================================================
// field positions
`define TC_IRQ0_EDGE       0
`define TC_IRQ0_PEND       1
`define TC_IRQ1_EDGE       2
`define TC_IRQ1_PEND       3
`define RTC_INTERVAL_EN    1
`define RTC_INTERVAL_FLAG  2
`define RTC_ALARM_FLAG     6
`define RTC2_ALARM_EN_MSB  3
`define RTC2_ALARM_EN_LSB  0
`define PC_LCD_EN          0
`define PC_SLEEP_REQ       4
`define PIE_DC_SENSE       3
`define PIF_DC_SENSE       3
`define PIF_SUPPLY_REST    7
`define DELTA_TEMP_EN      0
`define PER_RX_FUNC_MSB    1
`define PER_RX_FUNC_LSB    0
`define PER_SUPPLY_SRC     6
`define PER_RX_EDGE_FLAG   7
`define IPC_IRQ0_WAKE      0
`define IPC_IRQ1_MSB       3
`define IPC_IRQ1_LSB       2

// ==========================================================================
// codes, pin slots and reset values
`define RX_WAKE_CODE       2'b11
`define IRQ1_WAKE_CODE     2'b11
`define OPSTATE_MAINS      2'h0
`define OPSTATE_BATTERY    2'h1
`define OPSTATE_SLEEP      2'h2
`define PIN_IRQ0           0
`define PIN_IRQ1           1
`define PIN_RX             2
`define PIN_RESET          3
`define PIN_MAINS          4
`define NUM_PINS           5
`define REG_RST            8'h00

`endif

// ===== sleep_wakeup_control_pkg.sv
// Purpose: types for the deep sleep wake logic
// Assumes: sleep_wakeup_control_defs.svh holds the numbers
// Notes:   all state of the block is one packed struct
`include "sleep_wakeup_control_defs.svh"

// ==========================================================================
// package
package sleep_wakeup_control_pkg;

  typedef enum logic [1:0] {
    MAINS_RUN,
    BATTERY_RUN,
    DEEP_SLEEP,
    WAKING
  } op_state_t;

  typedef struct packed {
    op_state_t                 state;
    logic [7:0]                timer_control;
    logic [7:0]                rtc_config;
    logic [7:0]                rtc_config_second;
    logic [7:0]                port0_pullup_enable;
    logic [7:0]                port1_pullup_enable;
    logic [7:0]                port2_pullup_enable;
    logic [7:0]                power_control;
    logic [7:0]                power_irq_enables;
    logic [7:0]                delta_threshold_config;
    logic [7:0]                peripheral_config;
    logic [7:0]                power_irq_flags;
    logic [7:0]                irq_pin_config;
    logic [3:0][7:0]           retained_scratch;
    logic [`NUM_PINS-1:0]      sync1;
    logic [`NUM_PINS-1:0]      sync2;
    logic [`NUM_PINS-1:0]      sync3;
    logic [`NUM_PINS-1:0]      filt;
    logic                      rd_wait;
    logic                      wr_pend;
    logic [7:0]                idx;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      wake_req;
    logic                      core_power_en;
    logic                      core_reset;
    logic [1:0]                op_code;
    logic                      power_irq_req;
    logic                      rtc_irq_req;
  } sw_state_t;

endpackage : sleep_wakeup_control_pkg

// ===== sleep_wakeup_control_props.sv
// Purpose: port-level assertions for the deep sleep wake logic
// Assumes: one clock, srst synchronous and active high
// Notes:   bound onto every sleep_wakeup_control instance
`timescale 1ns/10ps
`default_nettype none

module sleep_wakeup_control_props (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       reset_pin_n,
  input wire logic       switched_supply_source,
  input wire logic       wake_req,
  input wire logic       core_power_en,
  input wire logic       core_reset,
  input wire logic [1:0] op_state,
  input wire logic       pins_input_only
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // bus timing
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_taken |=> one_wait)
    else $error("read without exactly one wait state");

  // ==========================================================================
  // sleep entry and wake sequence
  sequence reset_low_asleep;
    op_state == 2'h2 && !reset_pin_n;
  endsequence
  a_sleep_outputs: assert property (
    op_state == 2'h2 |-> !core_power_en && core_reset && pins_input_only)
    else $error("sleep outputs wrong");
  a_sleep_entry: assert property (
    op_state == 2'h2 && $past(op_state) != 2'h2 |-> $past(op_state) == 2'h1)
    else $error("sleep entered from a state other than battery run");
  a_wake_source: assert property (wake_req |-> $past(op_state) == 2'h2)
    else $error("wake request outside sleep");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_wake_restart: assert property (
    wake_req |-> core_reset ##1 (core_power_en && !core_reset))
    else $error("core not restarted from reset after wake");
  a_reset_wake: assert property (reset_low_asleep |-> ##[1:8] wake_req)
    else $error("reset pin did not wake");
  a_supply_wake: assert property (
    op_state == 2'h2 && switched_supply_source |-> ##[1:8] wake_req)
    else $error("supply restore did not wake");
endmodule : sleep_wakeup_control_props

bind sleep_wakeup_control sleep_wakeup_control_props props_inst (
  .core_clk, .srst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .reset_pin_n, .switched_supply_source, .wake_req, .core_power_en,
  .core_reset, .op_state, .pins_input_only);

`default_nettype wire

// ===== sleep_wakeup_control_tb.sv
// Purpose: self-checking bench for the deep sleep wake logic
// Assumes: single slave, hready fed back from hreadyout
// Notes:   each wake source is tried from deep sleep in turn
`timescale 1ns/10ps
`default_nettype none

module sleep_wakeup_control_tb;
  import sleep_wakeup_control_pkg::*;
  logic        core_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic        wake_req, core_power_en, core_reset, lcd_enable;
  logic        pins_input_only, power_irq_req, rtc_irq_req;
  logic        temp_change_evt, dc_sense_change_evt, rtc_interval_evt;
  logic        rtc_alarm_evt, ext_irq_zero_n, ext_irq_one_n;
  logic        second_uart_receive, reset_pin_n, switched_supply_source;
  logic [1:0]  htrans, op_state;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  port0_pullup, port1_pullup, port2_pullup;
  int          n_fail, n_compared;
  // wake table: trigger, setup reg/value, check reg/value, clear value
  int          tk [7] = '{0, 2, 3, 4, 5, 6, 7};
  logic [7:0]  si [7] = '{8'hF3, 8'hA1, 8'hA2, 8'hFF, 8'hFF, 8'hF4, 8'h80};
  logic [7:0]  sv [7] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h0C, 8'h03, 8'h00};
  logic [7:0]  ci [7] = '{8'hF3, 8'hA1, 8'hA1, 8'h88, 8'h88, 8'hF4, 8'hF8};
  logic [7:0]  ce [7] = '{8'h01, 8'h06, 8'h40, 8'h05, 8'h05, 8'h83, 8'h00};
  logic [7:0]  cv [7] = '{8'h00, 8'h04, 8'h40, 8'h05, 8'h05, 8'h80, 8'h00};
  logic [7:0]  ri [7] = '{8'hB2, 8'hB3, 8'hB4, 8'hFB, 8'hFC, 8'hFD, 8'hFE};

  assign hready = hreadyout;
  always #25 core_clk = ~core_clk;

  // ==========================================================================
  // design and its surroundings
  sleep_wakeup_control sleep_wakeup_control_inst (
    .core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .temp_change_evt,
    .dc_sense_change_evt, .rtc_interval_evt, .rtc_alarm_evt,
    .ext_irq_zero_n, .ext_irq_one_n, .second_uart_receive, .reset_pin_n,
    .switched_supply_source, .wake_req, .core_power_en, .core_reset,
    .op_state, .lcd_enable, .pins_input_only, .port0_pullup,
    .port1_pullup, .port2_pullup, .power_irq_req, .rtc_irq_req);
  wake_source_model wake_source_model_inst (
    .core_clk, .temp_change_evt, .dc_sense_change_evt, .rtc_interval_evt,
    .rtc_alarm_evt, .ext_irq_zero_n, .ext_irq_one_n, .second_uart_receive,
    .reset_pin_n, .switched_supply_source);

  // ==========================================================================
  // bus and check tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask : chk

  // one single AHB-Lite transfer; waits on hready, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, i, 2'h0};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), {24'h0, e}, q);
  endtask : rdc

  // sleep entry keeps the display on so its survival is visible
  task automatic sleep_now;
    wr(8'hC5, 8'h11);
    repeat (3) @(posedge core_clk);
    chk("op_state", 32'h2, {30'h0, op_state});
    chk("lcd_enable", 32'h1, {31'h0, lcd_enable});
    chk("pins_input_only", 32'h1, {31'h0, pins_input_only});
    chk("core_power_en", 32'h0, {31'h0, core_power_en});
    chk("core_reset", 32'h1, {31'h0, core_reset});
  endtask : sleep_now

  // bounded wait, the pins add a few synchroniser cycles
  task automatic wake_wait;
    int n;
    n = 0;
    while (wake_req !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("wake_req", 32'h1, {31'h0, wake_req});
    repeat (4) @(posedge core_clk);
  endtask : wake_wait

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // ==========================================================================
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    srst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("op_state", 32'h0, {30'h0, op_state});
    wr(8'hF8, 8'hFF);
    for (int j = 0; j < 7; j++) wr(ri[j], 8'h5A ^ j[7:0]);
    for (int j = 0; j < 7; j++) rdc(ri[j], 8'h5A ^ j[7:0]);
    chk("port2_pullup", 32'h58, {24'h0, port2_pullup});
    chk("port0_pullup", 32'h5A, {24'h0, port0_pullup});
    chk("port1_pullup", 32'h5B, {24'h0, port1_pullup});
    wr(8'h80, 8'hFF);
    rdc(8'h80, 8'h00);
    wr(8'h88, 8'h05);
    wake_source_model_inst.supply(1'b0);
    repeat (8) @(posedge core_clk);
    chk("op_state", 32'h1, {30'h0, op_state});
    // masked dc sense change: flag only, no wake
    sleep_now();
    wake_source_model_inst.trig(1);
    repeat (10) @(posedge core_clk);
    chk("op_state", 32'h2, {30'h0, op_state});
    rdc(8'hFB, 8'h59);
    rdc(8'hF8, 8'h08);
    wr(8'hF8, 8'h08);
    rdc(8'hF8, 8'h00);
    wr(8'hEC, 8'h08);
    wake_source_model_inst.trig(1);
    wake_wait();
    chk("power_irq_req", 32'h1, {31'h0, power_irq_req});
    wr(8'hF8, 8'h08);
    wr(8'hEC, 8'h00);
    // each remaining source wakes from sleep into battery run
    for (int j = 0; j < 7; j++)
    begin
      wr(si[j], sv[j]);
      sleep_now();
      wake_source_model_inst.trig(tk[j]);
      wake_wait();
      chk("op_state", 32'h1, {30'h0, op_state});
      chk("core_reset", 32'h0, {31'h0, core_reset});
      if (j == 1 || j == 2)
        chk("rtc_irq_req", 32'h1, {31'h0, rtc_irq_req});
      rdc(ci[j], ce[j]);
      wr(ci[j], cv[j]);
      wr(si[j], 8'h00);
      wake_source_model_inst.rest();
    end
    // main supply returns while asleep
    sleep_now();
    wake_source_model_inst.supply(1'b1);
    wake_wait();
    chk("op_state", 32'h0, {30'h0, op_state});
    rdc(8'hF8, 8'h80);
    rdc(8'hF4, 8'h40);
    close_out();
  end
endmodule : sleep_wakeup_control_tb

`default_nettype wire

// ===== wake_source_model.sv
// Purpose: always-on peripherals and external pins around the wake logic
// Assumes: events are one-cycle strobes, pins idle high on pull-ups
// Notes:   driven through tasks called by the testbench
`timescale 1ns/10ps
`default_nettype none

module wake_source_model (
  input wire logic core_clk,
  output logic     temp_change_evt,
  output logic     dc_sense_change_evt,
  output logic     rtc_interval_evt,
  output logic     rtc_alarm_evt,
  output logic     ext_irq_zero_n,
  output logic     ext_irq_one_n,
  output logic     second_uart_receive,
  output logic     reset_pin_n,
  output logic     switched_supply_source
);
  logic [3:0] evt_q;
  logic [4:0] pin_q;

  // ==========================================================================
  // outputs: pins rest at their pull-up level between uses
  assign {rtc_alarm_evt, rtc_interval_evt, dc_sense_change_evt,
          temp_change_evt} = evt_q;
  assign {switched_supply_source, reset_pin_n, second_uart_receive,
          ext_irq_one_n, ext_irq_zero_n} = pin_q;
  initial
  begin
    evt_q = 4'h0;
    pin_q = 5'h1F;
  end

  // strobe an event (0..3) or pull a pin low (4..7)
  task automatic trig(input int k);
    @(posedge core_clk);
    if (k < 4)
      evt_q[k] <= 1'b1;
    else
      pin_q[k-4] <= 1'b0;
    @(posedge core_clk);
    evt_q <= 4'h0;
  endtask : trig

  // release the four wake pins to their idle level, the supply source stays as set
  task automatic rest;
    @(posedge core_clk);
    pin_q[3:0] <= 4'hF;
  endtask : rest

  // source of the switched supply node, 1 = main
  task automatic supply(input logic v);
    @(posedge core_clk);
    pin_q[4] <= v;
  endtask : supply
endmodule : wake_source_model

`default_nettype wire
